// file: pkg/i2c_stop_pkg.sv
package i2c_stop_pkg;

  // Register byte offsets
  localparam logic [3:0] ctrl_offset = 4'h0;
  localparam logic [3:0] data_offset = 4'h4;
  localparam logic [3:0] ext_offset = 4'h8;
  localparam logic [3:0] status_offset = 4'hc;

  // Control register fields
  localparam int ctrl_ice_bit = 0;
  localparam int ctrl_mst_bit = 1;
  localparam int ctrl_trs_bit = 2;
  localparam int ctrl_bus_busy_flag_bit = 3;
  localparam int ctrl_scp_bit = 4;
  localparam int ctrl_div_lsb = 5;
  localparam int ctrl_div_w = 3;

  // Extended control fields
  localparam int ext_cancel_lsb = 0;
  localparam int ext_clock_range_select_bit = 2;
  localparam logic [1:0] cancel_all = 2'h3;

  // Status fields
  localparam int stat_full_bit = 0;
  localparam int stat_lost_bit = 1;
  localparam int stat_fifo_bit = 2;

  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [2:0] ext_reset = 3'h0;

  // Timing and sizes
  localparam int clk_mhz = 50;
  localparam int margin_wide = 12;
  localparam int margin_narrow = 6;
  localparam logic [7:0] div_base = 8'h0e;
  localparam int fifo_depth = 32;
  localparam int data_w = 8;

  typedef struct packed {
    logic interface_enable;
    logic master_select;
    logic transmit_direction_select;
    logic [1:0] cancel;
    logic clock_range_select;
    logic [2:0] div;
  } ctrl_t;

  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } pins_t;

endpackage

// file: src/byte_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
  parameter int width = 8,
  parameter int depth = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [width-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [width-1:0] out_data_o
);
  localparam int aw = $clog2(depth);
  logic [width-1:0] mem [depth];
  logic [aw:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic do_wr, do_rd;

  assign in_ready_o = (wr_ff - rd_ff) != (aw+1)'(depth);
  assign out_valid_o = wr_ff != rd_ff;
  assign out_data_o = mem[rd_ff[aw-1:0]];
  assign do_wr = in_valid_i && in_ready_o;
  assign do_rd = out_valid_o && out_ready_i;

  always_comb begin
    nxt_wr = wr_ff + (aw+1)'(do_wr);
    nxt_rd = rd_ff + (aw+1)'(do_rd);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
    end
    if (do_wr) begin
      mem[wr_ff[aw-1:0]] <= in_data_i;
    end
  end
endmodule
`default_nettype wire

// file: src/i2c_stop_ctrl.sv
// The Wishbone slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module i2c_stop_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);
  ////////////////////////////////////////////////////////////////////////////
  typedef enum {idle, start_a, start_b, bit_lo, bit_hi, stop_lo, stop_hi,
    stop_end} phase_t;

  i2c_stop_pkg::ctrl_t ctrl_ff, nxt_ctrl;
  phase_t phase_ff, nxt_phase;
  logic busy_ff, nxt_busy;
  logic stop_req_ff, nxt_stop_req;
  logic start_req_ff, nxt_start_req;
  logic [11:0] cnt_ff, nxt_cnt;
  logic [3:0] bit_ff, nxt_bit;
  logic [7:0] shift_ff, nxt_shift;
  logic [7:0] rxbuf_ff, nxt_rxbuf;
  logic full_ff, nxt_full;
  logic held_ff, nxt_held;
  logic lost_ff, nxt_lost;
  logic go_ff, nxt_go;
  logic sda_oe_ff, nxt_sda_oe;
  logic scl_oe_ff, nxt_scl_oe;
  logic ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic [1:0] scl_sync_ff, sda_sync_ff;
  logic wr_acc, rd_acc;
  logic fifo_in_ready, fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic fifo_pop;

  // Wide enough for the slowest divider setting
  function automatic logic [11:0] half_period(input logic [2:0] div);
    half_period = 12'(i2c_stop_pkg::div_base) << div;
  endfunction

  // Slave data margin chosen by clock range
  function automatic logic [11:0] margin(input logic clock_range_select);
    margin = clock_range_select ? 12'(i2c_stop_pkg::margin_wide)
                  : 12'(i2c_stop_pkg::margin_narrow);
  endfunction

  assign wr_acc = cyc_i && stb_i && we_i && !ack_ff;
  assign rd_acc = cyc_i && stb_i && !we_i && !ack_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_i};
      sda_sync_ff <= {sda_sync_ff[0], sda_i};
    end
  end

  // Received bytes queue behind the receive buffer; a full queue stalls SCL
  byte_fifo #(.width(i2c_stop_pkg::data_w), .depth(i2c_stop_pkg::fifo_depth))
    u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(go_ff),
    .in_ready_o(fifo_in_ready),
    .in_data_i(shift_ff),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_busy = busy_ff;
    nxt_stop_req = stop_req_ff;
    nxt_start_req = start_req_ff;
    nxt_rxbuf = rxbuf_ff;
    nxt_full = full_ff;
    nxt_held = held_ff;
    nxt_lost = lost_ff;
    nxt_ack = wr_acc || rd_acc;
    nxt_rdat = rdat_ff;
    fifo_pop = 1'b0;
    nxt_phase = phase_ff;
    nxt_cnt = cnt_ff;
    nxt_bit = bit_ff;
    nxt_shift = shift_ff;
    nxt_go = 1'b0;
    nxt_sda_oe = sda_oe_ff;
    nxt_scl_oe = scl_oe_ff;
    // Buffer refill from queue
    if (!full_ff && fifo_out_valid) begin
      nxt_rxbuf = fifo_out_data;
      nxt_full = 1'b1;
      fifo_pop = 1'b1;
    end
    if (wr_acc && sel_i[0]) begin
      unique case (adr_i)
        i2c_stop_pkg::ctrl_offset: begin
          nxt_ctrl.interface_enable = dat_i[i2c_stop_pkg::ctrl_ice_bit];
          nxt_ctrl.master_select = dat_i[i2c_stop_pkg::ctrl_mst_bit];
          nxt_ctrl.transmit_direction_select = dat_i[i2c_stop_pkg::ctrl_trs_bit];
          nxt_ctrl.div = dat_i[i2c_stop_pkg::ctrl_div_lsb +:
                               i2c_stop_pkg::ctrl_div_w];
          if (!dat_i[i2c_stop_pkg::ctrl_bus_busy_flag_bit] &&
              !dat_i[i2c_stop_pkg::ctrl_scp_bit] && busy_ff) begin
            nxt_stop_req = 1'b1;
          end
          if (dat_i[i2c_stop_pkg::ctrl_bus_busy_flag_bit] &&
              !dat_i[i2c_stop_pkg::ctrl_scp_bit]) begin
            nxt_start_req = 1'b1;
          end
        end
        i2c_stop_pkg::ext_offset: begin
          nxt_ctrl.cancel = dat_i[i2c_stop_pkg::ext_cancel_lsb +: 2];
          nxt_ctrl.clock_range_select = dat_i[i2c_stop_pkg::ext_clock_range_select_bit];
        end
        default: ;
      endcase
    end
    if (rd_acc) begin
      unique case (adr_i)
        i2c_stop_pkg::ctrl_offset:
          nxt_rdat = {24'h0, ctrl_ff.div, 1'b0, busy_ff, ctrl_ff.transmit_direction_select,
                      ctrl_ff.master_select, ctrl_ff.interface_enable};
        i2c_stop_pkg::data_offset: begin
          nxt_rdat = {24'h0, rxbuf_ff};
          // Reading in receive mode frees the buffer and resumes SCL;
          // without cancel a read during a pending stop is not honoured
          if (ctrl_ff.interface_enable && !ctrl_ff.transmit_direction_select &&
              (!stop_req_ff ||
               ctrl_ff.cancel == i2c_stop_pkg::cancel_all)) begin
            if (full_ff) begin
              nxt_full = 1'b0;
            end
            // Parked byte moves on from the shift register
            if (held_ff) begin
              nxt_go = 1'b1;
            end
            nxt_held = 1'b0;
          end
        end
        i2c_stop_pkg::ext_offset:
          nxt_rdat = {29'h0, ctrl_ff.clock_range_select, ctrl_ff.cancel};
        i2c_stop_pkg::status_offset:
          nxt_rdat = {29'h0, fifo_out_valid, lost_ff, full_ff};
        default: nxt_rdat = 32'h0;
      endcase
    end
    // Clear first so a same-cycle loss still sets the flag
    if (lost_ff && rd_acc && adr_i == i2c_stop_pkg::status_offset) begin
      nxt_lost = 1'b0;
    end
    // Bit engine
    if (cnt_ff != 12'h0) begin
      nxt_cnt = cnt_ff - 12'h1;
    end else begin
      unique case (phase_ff)
        idle: begin
          if (start_req_ff && ctrl_ff.interface_enable && ctrl_ff.master_select) begin
            nxt_start_req = 1'b0;
            nxt_sda_oe = 1'b1;
            nxt_busy = 1'b1;
            nxt_phase = start_a;
            nxt_cnt = half_period(ctrl_ff.div);
          end
        end
        start_a: begin
          nxt_scl_oe = 1'b1;
          nxt_phase = start_b;
          nxt_cnt = half_period(ctrl_ff.div);
        end
        start_b: begin
          nxt_sda_oe = 1'b0;
          nxt_bit = 4'h0;
          nxt_phase = bit_lo;
          nxt_cnt = half_period(ctrl_ff.div);
        end
        bit_lo: begin
          if (stop_req_ff) begin
            nxt_sda_oe = 1'b1;
            nxt_phase = stop_lo;
          end else if (sda_oe_ff != (bit_ff == 4'h8)) begin
            // Master ACK on ninth bit; data moves only with clock low
            nxt_sda_oe = bit_ff == 4'h8;
          end else if (!held_ff) begin
            nxt_scl_oe = 1'b0;
            nxt_phase = bit_hi;
          end
          nxt_cnt = half_period(ctrl_ff.div);
        end
        bit_hi: begin
          if (scl_sync_ff[1]) begin
            if (bit_ff < 4'h8) begin
              nxt_shift = {shift_ff[6:0], sda_sync_ff[1]};
            end
            nxt_scl_oe = 1'b1;
            nxt_phase = bit_lo;
            nxt_cnt = margin(ctrl_ff.clock_range_select);
            if (bit_ff == 4'h8) begin
              nxt_bit = 4'h0;
              // Byte stays in shift register while buffer is occupied
              if (full_ff || !fifo_in_ready) begin
                nxt_held = 1'b1;
              end else begin
                nxt_go = 1'b1;
              end
            end else begin
              nxt_bit = bit_ff + 4'h1;
            end
          end
        end
        stop_lo: begin
          nxt_scl_oe = 1'b0;
          nxt_phase = stop_hi;
          nxt_cnt = half_period(ctrl_ff.div);
        end
        stop_hi: begin
          if (scl_sync_ff[1]) begin
            nxt_sda_oe = 1'b0;
            nxt_phase = stop_end;
            nxt_cnt = half_period(ctrl_ff.div);
          end
        end
        stop_end: begin
          // Busy clears only after stop is on the bus
          nxt_busy = 1'b0;
          nxt_stop_req = 1'b0;
          nxt_held = 1'b0;
          nxt_phase = idle;
          // Transmit-direction stop without cancel drops the parked byte
          if (held_ff) begin
            if (ctrl_ff.transmit_direction_select &&
                ctrl_ff.cancel != i2c_stop_pkg::cancel_all) begin
              nxt_lost = 1'b1;
            end else begin
              nxt_go = 1'b1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= '0;
      phase_ff <= idle;
      busy_ff <= 1'b0;
      stop_req_ff <= 1'b0;
      start_req_ff <= 1'b0;
      cnt_ff <= 12'h0;
      bit_ff <= 4'h0;
      shift_ff <= 8'h0;
      rxbuf_ff <= 8'h0;
      full_ff <= 1'b0;
      held_ff <= 1'b0;
      lost_ff <= 1'b0;
      go_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      phase_ff <= nxt_phase;
      busy_ff <= nxt_busy;
      stop_req_ff <= nxt_stop_req;
      start_req_ff <= nxt_start_req;
      cnt_ff <= nxt_cnt;
      bit_ff <= nxt_bit;
      shift_ff <= nxt_shift;
      rxbuf_ff <= nxt_rxbuf;
      full_ff <= nxt_full;
      held_ff <= nxt_held;
      lost_ff <= nxt_lost;
      go_ff <= nxt_go;
      sda_oe_ff <= nxt_sda_oe;
      scl_oe_ff <= nxt_scl_oe;
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  // Open drain: pins only ever pull low
  always_comb begin
    dat_o = rdat_ff;
    ack_o = ack_ff;
    scl_o = 1'b0;
    sda_o = 1'b0;
    scl_oe_o = scl_oe_ff;
    sda_oe_o = sda_oe_ff;
  end
endmodule
`default_nettype wire

// file: tb/i2c_rx_slave.sv
`timescale 1ns/100ps
`default_nettype none
module i2c_rx_slave #(
  parameter logic [7:0] first_byte = 8'ha5
) (
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe_o
);
  logic [7:0] tx_byte;
  logic [3:0] bit_cnt;
  logic quiet;
  logic scl_q;
  logic sda_q;
  initial begin
    tx_byte = first_byte;
    bit_cnt = 4'h0;
    quiet = 1'b1;
    sda_oe_o = 1'b0;
    scl_q = 1'b1;
    sda_q = 1'b1;
  end
  // Bytes keep bit 7 high so a held line never blocks a stop
  always @(scl_i, sda_i) begin
    if (scl_i && scl_q && sda_q && !sda_i) begin
      bit_cnt = 4'h0;
      quiet = 1'b0;
    end else if (scl_i && scl_q && !sda_q && sda_i) begin
      quiet = 1'b1;
      sda_oe_o = 1'b0;
    end else if (scl_i && !scl_q) begin
      bit_cnt = bit_cnt + 4'h1;
      if (bit_cnt == 4'h9) tx_byte = tx_byte + 8'h01;
    end else if (!scl_i && scl_q && !quiet) begin
      if (bit_cnt == 4'h9) bit_cnt = 4'h0;
      sda_oe_o = (bit_cnt < 4'h8) && !tx_byte[3'h7 - bit_cnt[2:0]];
    end
    scl_q = scl_i;
    sda_q = sda_i;
  end
endmodule
`default_nettype wire

// file: tb/i2c_stop_chk.sv
`timescale 1ns/100ps
`default_nettype none
module i2c_stop_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_o,
  input wire logic sda_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  // Data released while clock is released: only a stop does that
  sequence s_stop;
    $fell(sda_oe_o) && !scl_oe_o;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  a_ack_after_req: assert property (s_req |=> ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_ack_needs_req: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without request");
  a_rdata_hold: assert property (
    !(cyc_i && stb_i && !we_i && !ack_o) |=> $stable(dat_o))
    else $error("read data changed without read");
  a_reset_idle: assert property (disable iff (1'b0)
    rst_i |=> !ack_o && !scl_oe_o && !sda_oe_o && dat_o == 32'h0)
    else $error("outputs active in reset");
  a_stop_setup: assert property (
    s_stop |-> $past(scl_oe_o, 2) == 1'b0)
    else $error("stop without clock high first");
  a_bus_free: assert property (s_stop |=> !sda_oe_o [*8])
    else $error("line reclaimed too soon after stop");
  a_pins_low: assert property (!scl_o && !sda_o)
    else $error("pin level not low");
endmodule
bind i2c_stop_ctrl i2c_stop_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .dat_o(dat_o),
  .ack_o(ack_o), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o));
`default_nettype wire

// file: tb/i2c_stop_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module i2c_stop_ctrl_tb;
  typedef struct packed {
    logic w;
    logic [3:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } row_t;
  localparam logic [3:0] ctl = i2c_stop_pkg::ctrl_offset;
  localparam logic [3:0] dat = i2c_stop_pkg::data_offset;
  localparam logic [3:0] ext = i2c_stop_pkg::ext_offset;
  localparam logic [3:0] sts = i2c_stop_pkg::status_offset;
  localparam row_t rows [8] = '{
    '{1'b0, ctl, 8'h00, i2c_stop_pkg::ctrl_reset},
    '{1'b0, ext, 8'h00, {5'h00, i2c_stop_pkg::ext_reset}},
    '{1'b1, ext, 8'h07, 8'h00},
    '{1'b0, ext, 8'h00, 8'h07},
    '{1'b1, ext, 8'h00, 8'h00},
    '{1'b1, 4'h2, 8'hff, 8'h00},
    '{1'b0, 4'h2, 8'h00, 8'h00},
    '{1'b0, sts, 8'h00, 8'h00}
  };
  logic clk_i, rst_i, cyc, stb, we, ack_o, slv_oe;
  logic scl_o, scl_oe_o, sda_o, sda_oe_o;
  logic [3:0] adr;
  logic [31:0] wdat, dat_o;
  int err_count = 0;
  int n_checks = 0;
  wire scl_w = !scl_oe_o;
  wire sda_w = !(sda_oe_o || slv_oe);
  always #10 clk_i = ~clk_i;
  i2c_stop_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat),
    .dat_o(dat_o), .ack_o(ack_o), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o));
  i2c_rx_slave slave (.scl_i(scl_w), .sda_i(sda_w), .sda_oe_o(slv_oe));
  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic fail;
    err_count++;
    complete_run;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) fail;
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic poll(input logic [3:0] a, input int b, input logic v);
    logic [7:0] q;
    int n;
    n = 0;
    do begin
      bus(1'b0, a, 8'h00, q);
      n++;
    end while (q[b] !== v && n < 200);
    if (q[b] !== v) fail;
  endtask
  // Engine parks with clock low once the receive buffer is occupied and the next byte is in
  task automatic hold_wait;
    int n, h;
    n = 0;
    h = 0;
    while (h < 60 && n < 4000) begin
      @(posedge clk_i);
      n++;
      h = (scl_oe_o === 1'b1) ? h + 1 : 0;
    end
    if (h < 60) fail;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] q;
    clk_i = 1'b0;
    rst_i = 1'b1;
    {cyc, stb, we} = 3'h0;
    adr = 4'h0;
    wdat = 32'h0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d, q);
      if (!rows[i].w) chk("register", q, rows[i].e);
    end
    bus(1'b1, ctl, 8'h0b, q);
    hold_wait;
    bus(1'b1, ctl, 8'h03, q);
    poll(ctl, i2c_stop_pkg::ctrl_bus_busy_flag_bit, 1'b0);
    bus(1'b0, dat, 8'h00, q);
    chk("first byte", q, 8'ha5);
    poll(sts, i2c_stop_pkg::stat_full_bit, 1'b1);
    bus(1'b0, dat, 8'h00, q);
    chk("second byte", q, 8'ha6);
    repeat (60) @(posedge clk_i);
    bus(1'b1, ctl, 8'h0b, q);
    hold_wait;
    bus(1'b1, ctl, 8'h07, q);
    poll(ctl, i2c_stop_pkg::ctrl_bus_busy_flag_bit, 1'b0);
    bus(1'b1, ctl, 8'h03, q);
    bus(1'b0, sts, 8'h00, q);
    chk("lost flag", {7'h00, q[1]}, 8'h01);
    bus(1'b0, dat, 8'h00, q);
    chk("kept byte", q, 8'ha7);
    bus(1'b0, sts, 8'h00, q);
    chk("status after", {6'h00, q[1:0]}, 8'h00);
    // Queue path seen through the top: parked byte waits behind buffer
    repeat (60) @(posedge clk_i);
    bus(1'b1, ctl, 8'h0b, q);
    hold_wait;
    bus(1'b1, ctl, 8'h03, q);
    poll(ctl, i2c_stop_pkg::ctrl_bus_busy_flag_bit, 1'b0);
    bus(1'b0, sts, 8'h00, q);
    chk("queue filled", {5'h00, q[2:0]}, 8'h05);
    bus(1'b0, dat, 8'h00, q);
    chk("queue head", q, 8'ha9);
    bus(1'b0, sts, 8'h00, q);
    chk("queue drained", {5'h00, q[2:0]}, 8'h01);
    bus(1'b0, dat, 8'h00, q);
    chk("queue next", q, 8'haa);
    complete_run;
  end
endmodule
`default_nettype wire
